// >>> design/lpe_mem_ctrl.sv
/*
 Memory controller end: APB register slave, command issue, power-down
 entry and exit with interval checks, refresh scheduling by temperature.
 Assumes an APB master on sys_clk and the device end on the link.
*/
// Functional notes
// - Refresh faster as case temperature rises
// - Self refresh hot only with an option
// - Range bit gives self-refresh temperature range
// - Never set both self-refresh bits together
// - Device picks self-refresh rate when automatic
// - Above 105 use external refresh only; the device end keeps sr_ok_q set under ASR in every band
// - Options decide device self-refresh temperature range
// - Power-down entry: enable low with NOP
// - Keep enable high during register, data ops
// - Enable may drop during activate, precharge, refresh
// - Only NOP while buffers shut down
// - Unlocked entry requires DLL reset afterwards
// - Open bank gives active power-down
// - Slow exit from precharge power-down switches DLL off
// - Slow exit from precharge power-down makes termination control asynchronous
// - Exit with enable high, hold, wait
// - Hold low minimum, leave before nine intervals
`timescale 1ns/100ps
module lpe_mem_ctrl #(
    parameter int REFI_CK = lpe_pkg::TREFI_CK
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    lpe_if.ctrl mem
);
    typedef enum {C_UP, C_PD, C_EXIT} lpe_cst_t;

    localparam logic [15:0] PD_MAX = 16'(lpe_pkg::TPD_MAX_REFI * REFI_CK);
    localparam logic [15:0] XPDLL = 16'(lpe_pkg::TXPDLL_CK);

    lpe_cst_t st_q;
    logic [3:0] ctrl_q;
    logic [15:0] gap_q;
    logic [15:0] pd_age_q;
    logic [15:0] ex_q;
    logic [15:0] exit_age_q;
    logic [15:0] ref_cnt_q;
    logic ref_due_q;
    logic ref_since_exit_q;
    logic asr_q;
    logic srt_q;
    logic fast_q;
    logic bc4_q;
    logic dll_rst_req_q;
    logic sr_allowed_q;
    logic cke_q;
    lpe_pkg::lpe_cmd_t cmd_q;
    logic [2:0] ba_q;
    logic [12:0] addr_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;

    logic acc;
    logic cmd_wr;
    logic issue;
    logic enter;
    logic wake;
    logic [1:0] temp;
    lpe_pkg::lpe_cmd_t new_cmd;
    logic [2:0] new_ba;
    logic [12:0] new_addr;
    logic [15:0] new_gap;

    assign acc = psel & penable & !pready_q;
    assign cmd_wr = acc & pwrite & (paddr == lpe_pkg::REG_CMD);
    assign issue = cmd_wr & (st_q == C_UP);
    assign temp = ctrl_q[lpe_pkg::CTRL_TEMP_LSB +: 2];
    assign new_ba = pwdata[lpe_pkg::CMD_BA_LSB +: 3];
    assign new_gap = 16'(lpe_pkg::min_pden(new_cmd, bc4_q));

    always_comb begin
        new_cmd = (pwdata[3:0] > 4'(lpe_pkg::CMD_MPR)) ? lpe_pkg::CMD_NOP : lpe_pkg::lpe_cmd_t'(pwdata[3:0]);
        new_addr = pwdata[lpe_pkg::CMD_ADDR_LSB +: 13];
        if (new_cmd == lpe_pkg::CMD_MRS && new_ba == lpe_pkg::MR_BA_MR2 && new_addr[lpe_pkg::MR2_ASR_BIT]) begin
            new_addr[lpe_pkg::MR2_SRT_BIT] = 1'b0;
        end
    end

    assign enter = ctrl_q[lpe_pkg::CTRL_PDREQ_BIT] & (gap_q == 16'h0) & !issue & !ref_due_q
        & !(ref_since_exit_q & (exit_age_q < XPDLL));
    assign wake = !ctrl_q[lpe_pkg::CTRL_PDREQ_BIT] | cmd_wr | ref_due_q
        | (pd_age_q >= PD_MAX - 16'h1);

    // APB answers; command writes stall until the link is up
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            if (acc) begin
                prdata_q <= 32'h0;
                case (paddr)
                    lpe_pkg::REG_CTRL: begin
                        pready_q <= 1'b1;
                        prdata_q <= {28'h0, ctrl_q};
                    end
                    lpe_pkg::REG_CMD: begin
                        pready_q <= !pwrite | issue;
                    end
                    lpe_pkg::REG_STAT: begin
                        pready_q <= 1'b1;
                        prdata_q <= {26'h0, fast_q, dll_rst_req_q, sr_allowed_q, ref_due_q,
                            st_q == C_PD, gap_q == 16'h0};
                    end
                    default: begin
                        pready_q <= 1'b1;
                        pslverr_q <= 1'b1;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_q <= lpe_pkg::CTRL_RST;
        end else if (acc & pwrite & (paddr == lpe_pkg::REG_CTRL)) begin
            ctrl_q <= pwdata[3:0];
        end
    end

    // Command pins; NOP whenever nothing is issued
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cmd_q <= lpe_pkg::CMD_NOP;
            ba_q <= 3'h0;
            addr_q <= 13'h0;
        end else if (issue) begin
            cmd_q <= new_cmd;
            ba_q <= new_ba;
            addr_q <= new_addr;
        end else begin
            cmd_q <= lpe_pkg::CMD_NOP;
        end
    end

    // Shadow of mode bits the controller relies on
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            asr_q <= 1'b0;
            srt_q <= 1'b0;
            fast_q <= 1'b0;
            bc4_q <= 1'b0;
        end else if (issue && new_cmd == lpe_pkg::CMD_MRS) begin
            if (new_ba == lpe_pkg::MR_BA_MR2) begin
                asr_q <= new_addr[lpe_pkg::MR2_ASR_BIT];
                srt_q <= new_addr[lpe_pkg::MR2_SRT_BIT];
            end else if (new_ba == lpe_pkg::MR_BA_MR0) begin
                fast_q <= new_addr[lpe_pkg::MR0_FAST_BIT];
                bc4_q <= new_addr[1:0] == lpe_pkg::MR0_BC4_FIXED;
            end
        end
    end

    // Self refresh allowed at 85, and at 105 only with an option
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sr_allowed_q <= 1'b0;
        end else begin
            sr_allowed_q <= (temp == lpe_pkg::TEMP_85)
                | ((temp == lpe_pkg::TEMP_105) & (asr_q | srt_q));
        end
    end

    // Refresh interval shortened 2x, 4x, 8x by band
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ref_cnt_q <= 16'(REFI_CK);
            ref_due_q <= 1'b0;
        end else begin
            if (ref_cnt_q == 16'h0) begin
                ref_cnt_q <= 16'(REFI_CK) >> temp;
                ref_due_q <= 1'b1;
            end else begin
                ref_cnt_q <= ref_cnt_q - 16'h1;
                if (issue && new_cmd == lpe_pkg::CMD_REF) begin
                    ref_due_q <= 1'b0;
                end
            end
        end
    end

    // Longest interval still owed before entry is legal
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            gap_q <= 16'h0;
        end else if (issue) begin
            gap_q <= (gap_q > new_gap) ? gap_q - 16'h1 : new_gap;
        end else if (gap_q != 16'h0) begin
            gap_q <= gap_q - 16'h1;
        end
    end

    // DLL reset owed after entry with unlocked DLL
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dll_rst_req_q <= 1'b0;
        end else if (st_q == C_UP && enter && !ctrl_q[lpe_pkg::CTRL_DLLOK_BIT]) begin
            dll_rst_req_q <= 1'b1;
        end else if (issue && new_cmd == lpe_pkg::CMD_MRS && new_ba == lpe_pkg::MR_BA_MR0
            && new_addr[lpe_pkg::MR0_DLLRST_BIT]) begin
            dll_rst_req_q <= 1'b0;
        end
    end

    // Power-down sequencing on clock enable
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_q <= C_UP;
            cke_q <= 1'b1;
            pd_age_q <= 16'h0;
            ex_q <= 16'h0;
            exit_age_q <= 16'hffff;
            ref_since_exit_q <= 1'b0;
        end else begin
            if (exit_age_q != 16'hffff) begin
                exit_age_q <= exit_age_q + 16'h1;
            end
            if (issue && new_cmd == lpe_pkg::CMD_REF) begin
                ref_since_exit_q <= 1'b1;
            end
            case (st_q)
                C_UP: begin
                    if (enter) begin
                        st_q <= C_PD;
                        cke_q <= 1'b0;
                        pd_age_q <= 16'h1;
                        ref_since_exit_q <= 1'b0;
                    end
                end
                C_PD: begin
                    pd_age_q <= pd_age_q + 16'h1;
                    if (pd_age_q >= 16'(lpe_pkg::TPD_MIN_CK) && wake) begin
                        st_q <= C_EXIT;
                        cke_q <= 1'b1;
                        ex_q <= fast_q ? 16'(lpe_pkg::TXP_CK) : XPDLL;
                        exit_age_q <= 16'h1;
                    end
                end
                C_EXIT: begin
                    ex_q <= ex_q - 16'h1;
                    if (ex_q <= 16'h1) begin
                        st_q <= C_UP;
                    end
                end
                default: st_q <= C_UP;
            endcase
        end
    end

    assign mem.cke = cke_q;
    assign mem.cmd = cmd_q;
    assign mem.ba = ba_q;
    assign mem.addr = addr_q;
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
endmodule

// >>> design/lpe_pkg.sv
/*
 Shared constants, command encoding and timing helpers for the low-power
 entry pair: a memory controller end and a memory device end.
 Assumes a single 10 MHz clock common to both ends.
*/
package lpe_pkg;
    typedef enum logic [3:0] {
        CMD_NOP, CMD_DES, CMD_ACT, CMD_PRE, CMD_RD, CMD_RDA,
        CMD_WR, CMD_WRA, CMD_REF, CMD_MRS, CMD_ZQC, CMD_MPR
    } lpe_cmd_t;

    localparam int T_CK_NS = 100;

    // Least time rounds up, longest rounds down, never below one cycle
    function automatic int cyc_min(input int ns);
        int c;
        c = (ns + T_CK_NS - 1) / T_CK_NS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int cyc_max(input int ns);
        int c;
        c = ns / T_CK_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int RL_CK = 5;
    localparam int WL_CK = 5;
    localparam int TWR_NS = 15;
    localparam int WR_CK = cyc_min(TWR_NS);
    localparam int TMOD_CK = 12;
    localparam int TZQ_CK = 64;
    localparam int TCPDED_CK = 1;
    localparam int TCKE_CK = 3;
    localparam int TPD_MIN_CK = TCKE_CK;
    localparam int TXP_CK = 3;
    localparam int TXPDLL_NS = 24;
    localparam int TXPDLL_CK = (cyc_min(TXPDLL_NS) > 10) ? cyc_min(TXPDLL_NS) : 10;
    localparam int TANPD_CK = WL_CK - 1;
    localparam int TREFI_NS = 7800;
    localparam int TREFI_CK = cyc_max(TREFI_NS);
    localparam int TPD_MAX_REFI = 9;

    // Mode register fields
    localparam logic [2:0] MR_BA_MR0 = 3'h0;
    localparam logic [2:0] MR_BA_MR2 = 3'h2;
    localparam int MR0_FAST_BIT = 12;
    localparam int MR0_DLLRST_BIT = 8;
    localparam logic [1:0] MR0_BC4_FIXED = 2'h2;
    localparam int MR2_ASR_BIT = 6;
    localparam int MR2_SRT_BIT = 7;
    localparam int A_ALLBANK_BIT = 10;

    // Case temperature bands: <=85, <=105, <=115, <=125
    localparam logic [1:0] TEMP_85 = 2'h0;
    localparam logic [1:0] TEMP_105 = 2'h1;

    // Controller registers on APB
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CMD = 8'h04;
    localparam logic [7:0] REG_STAT = 8'h08;
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam int CTRL_PDREQ_BIT = 0;
    localparam int CTRL_DLLOK_BIT = 1;
    localparam int CTRL_TEMP_LSB = 2;
    localparam int CMD_BA_LSB = 4;
    localparam int CMD_ADDR_LSB = 7;

    // Cycles from a command until clock enable may be sampled low
    function automatic int min_pden(input lpe_cmd_t c, input logic bc4);
        int burst;
        burst = bc4 ? 2 : 4;
        case (c)
            CMD_RD, CMD_RDA, CMD_MPR: return RL_CK + 4 + 1;
            CMD_WR: return WL_CK + burst + WR_CK;
            CMD_WRA: return WL_CK + burst + WR_CK + 1;
            CMD_MRS: return TMOD_CK;
            CMD_ZQC: return TZQ_CK;
            CMD_ACT, CMD_PRE, CMD_REF: return 1;
            default: return 0;
        endcase
    endfunction
endpackage

// >>> design/lpe_if.sv
/*
 Command and clock-enable link between controller and memory device.
 Both ends share sys_clk; the controller drives every signal.
*/
`timescale 1ns/100ps
interface lpe_if;
    logic cke;
    lpe_pkg::lpe_cmd_t cmd;
    logic [2:0] ba;
    logic [12:0] addr;
    modport ctrl(output cke, output cmd, output ba, output addr);
    modport dev(input cke, input cmd, input ba, input addr);
endinterface

// >>> design/lpe_dram_end.sv
/*
 Memory device end: follows clock enable and commands, tracks open banks,
 power-down kind, DLL and termination-control state, self-refresh range.
 Assumes the controller keeps its own timing duties on the link.
*/
`timescale 1ns/100ps
module lpe_dram_end (
    input wire logic sys_clk,
    input wire logic rst,
    lpe_if.dev mem,
    input wire logic [1:0] temp_band,
    output logic in_pd_q,
    output logic act_pd_q,
    output logic dll_on_q,
    output logic buf_off_q,
    output logic odt_async_q,
    output logic [1:0] sr_rate_q,
    output logic sr_ok_q,
    output logic mr2_illegal_q
);
    typedef enum {D_UP, D_PD} lpe_dst_t;

    lpe_dst_t st_q;
    logic [7:0] bank_q;
    logic [15:0] busy_q;
    logic [15:0] cpd_q;
    logic [15:0] odt_hold_q;
    logic settled_q;
    logic asr_q;
    logic srt_q;
    logic fast_q;
    logic bc4_q;
    logic nopish;
    logic live;

    assign nopish = (mem.cmd == lpe_pkg::CMD_NOP) | (mem.cmd == lpe_pkg::CMD_DES);
    assign live = mem.cke & (st_q == D_UP);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            asr_q <= 1'b0;
            srt_q <= 1'b0;
            fast_q <= 1'b0;
            bc4_q <= 1'b0;
        end else if (live && mem.cmd == lpe_pkg::CMD_MRS) begin
            if (mem.ba == lpe_pkg::MR_BA_MR2) begin
                asr_q <= mem.addr[lpe_pkg::MR2_ASR_BIT];
                srt_q <= mem.addr[lpe_pkg::MR2_SRT_BIT];
            end else if (mem.ba == lpe_pkg::MR_BA_MR0) begin
                fast_q <= mem.addr[lpe_pkg::MR0_FAST_BIT];
                bc4_q <= mem.addr[1:0] == lpe_pkg::MR0_BC4_FIXED;
            end
        end
    end

    // Open-bank map and time left on the operation in flight
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bank_q <= 8'h0;
            busy_q <= 16'h0;
        end else begin
            if (busy_q != 16'h0) begin
                busy_q <= busy_q - 16'h1;
            end
            if (live && !nopish) begin
                busy_q <= 16'(lpe_pkg::min_pden(mem.cmd, bc4_q));
                case (mem.cmd)
                    lpe_pkg::CMD_ACT: bank_q[mem.ba] <= 1'b1;
                    lpe_pkg::CMD_PRE: begin
                        if (mem.addr[lpe_pkg::A_ALLBANK_BIT]) begin
                            bank_q <= 8'h0;
                        end else begin
                            bank_q[mem.ba] <= 1'b0;
                        end
                    end
                    lpe_pkg::CMD_RDA, lpe_pkg::CMD_WRA: bank_q[mem.ba] <= 1'b0;
                    default: bank_q <= bank_q;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_q <= D_UP;
            in_pd_q <= 1'b0;
            act_pd_q <= 1'b0;
            dll_on_q <= 1'b1;
            settled_q <= 1'b0;
            cpd_q <= 16'h0;
        end else begin
            case (st_q)
                D_UP: begin
                    if (!mem.cke && nopish) begin
                        st_q <= D_PD;
                        in_pd_q <= 1'b1;
                        settled_q <= 1'b0;
                        cpd_q <= 16'(lpe_pkg::TCPDED_CK);
                    end
                end
                D_PD: begin
                    if (cpd_q != 16'h0) begin
                        cpd_q <= cpd_q - 16'h1;
                    end
                    if (busy_q == 16'h0 && !settled_q) begin
                        settled_q <= 1'b1;
                        act_pd_q <= |bank_q;
                        dll_on_q <= (|bank_q) | fast_q;
                    end
                    if (mem.cke && nopish) begin
                        st_q <= D_UP;
                        in_pd_q <= 1'b0;
                        act_pd_q <= 1'b0;
                        dll_on_q <= 1'b1;
                        cpd_q <= 16'h0;
                    end
                end
                default: st_q <= D_UP;
            endcase
        end
    end

    // Buffers other than clock, enable, ODT and reset go off
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            buf_off_q <= 1'b0;
        end else begin
            buf_off_q <= (st_q == D_PD) && (cpd_q <= 16'h1) && !mem.cke;
        end
    end

    // Termination control asynchronous through slow-exit precharge power-down
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            odt_async_q <= 1'b0;
            odt_hold_q <= 16'h0;
        end else if (st_q == D_PD && busy_q == 16'h0 && !settled_q && !(|bank_q) && !fast_q) begin
            odt_async_q <= 1'b1;
            odt_hold_q <= 16'(lpe_pkg::TANPD_CK + lpe_pkg::TXPDLL_CK);
        end else if (odt_async_q && st_q == D_UP) begin
            odt_hold_q <= odt_hold_q - 16'h1;
            if (odt_hold_q <= 16'h1) begin
                odt_async_q <= 1'b0;
            end
        end
    end

    // Self-refresh rate and supported temperature range
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sr_rate_q <= 2'h0;
            sr_ok_q <= 1'b1;
            mr2_illegal_q <= 1'b0;
        end else begin
            mr2_illegal_q <= asr_q & srt_q;
            if (asr_q) begin
                sr_rate_q <= temp_band;
                sr_ok_q <= !srt_q;
            end else begin
                sr_rate_q <= srt_q ? lpe_pkg::TEMP_105 : lpe_pkg::TEMP_85;
                sr_ok_q <= (temp_band == lpe_pkg::TEMP_85)
                    | (srt_q & (temp_band == lpe_pkg::TEMP_105));
            end
        end
    end
endmodule

// >>> tb/lpe_checker.sv
/*
 Link checker for the low-power entry pair.
 Assumes the link signals and the shared clock and reset of both ends.
*/
`timescale 1ns/100ps
module lpe_checker #(
    parameter int REFI_CK = lpe_pkg::TREFI_CK
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cke,
    input wire lpe_pkg::lpe_cmd_t cmd,
    input wire logic [2:0] ba,
    input wire logic [12:0] addr
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    localparam int PD_MAX = lpe_pkg::TPD_MAX_REFI * REFI_CK;
    logic [6:0] gap_q, gap_d;
    logic [3:0] since_q;
    logic ref_q;
    logic [13:0] pd_q;
    logic idle;
    assign idle = (cmd == lpe_pkg::CMD_NOP) || (cmd == lpe_pkg::CMD_DES);
    // Cycles after a command that must still see enable high
    always_comb begin
        case (cmd)
            lpe_pkg::CMD_RD, lpe_pkg::CMD_RDA, lpe_pkg::CMD_MPR: gap_d = 7'h09;
            lpe_pkg::CMD_WR: gap_d = 7'h07;
            lpe_pkg::CMD_WRA: gap_d = 7'h08;
            lpe_pkg::CMD_MRS: gap_d = 7'h0b;
            lpe_pkg::CMD_ZQC: gap_d = 7'h3f;
            default: gap_d = 7'h00;
        endcase
        if (gap_q != 7'h00 && gap_q - 7'h01 > gap_d) begin
            gap_d = gap_q - 7'h01;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            gap_q <= 7'h00;
            pd_q <= 14'h0000;
        end else begin
            gap_q <= gap_d;
            pd_q <= cke ? 14'h0000 : pd_q + 14'h0001;
        end
    end
    // High cycles since exit, and refresh seen since then
    always_ff @(posedge sys_clk) begin
        if (rst || !cke) begin
            since_q <= rst ? 4'hf : 4'h0;
            ref_q <= 1'b0;
        end else begin
            since_q <= (since_q == 4'hf) ? since_q : since_q + 4'h1;
            ref_q <= ref_q || (cmd == lpe_pkg::CMD_REF);
        end
    end
    sequence s_low_hold;
        !cke [*3];
    endsequence
    sequence s_exit_hold;
        (cke && idle) [*3];
    endsequence
    property p_entry_idle;
        $fell(cke) |-> idle;
    endproperty
    property p_low_hold;
        $fell(cke) |-> s_low_hold;
    endproperty
    property p_exit_hold;
        $rose(cke) |-> s_exit_hold;
    endproperty
    property p_pd_idle;
        !cke |-> idle;
    endproperty
    property p_gap;
        gap_q != 7'h00 |-> cke;
    endproperty
    property p_ref_gap;
        $fell(cke) && ref_q |-> since_q >= 4'ha;
    endproperty
    property p_pd_max;
        !cke |-> pd_q < PD_MAX;
    endproperty
    property p_mr2;
        cmd == lpe_pkg::CMD_MRS && ba == lpe_pkg::MR_BA_MR2 && addr[lpe_pkg::MR2_ASR_BIT]
            |-> !addr[lpe_pkg::MR2_SRT_BIT];
    endproperty
    a_entry_idle: assert property (p_entry_idle)
        else $error("enable fell without an idle command");
    a_low_hold: assert property (p_low_hold)
        else $error("enable low shorter than three cycles");
    a_exit_hold: assert property (p_exit_hold)
        else $error("exit not held with idle commands");
    a_pd_idle: assert property (p_pd_idle)
        else $error("command issued in power-down");
    a_gap: assert property (p_gap)
        else $error("enable low before command interval ended");
    a_ref_gap: assert property (p_ref_gap)
        else $error("re-entry too soon after exit with refresh");
    a_pd_max: assert property (p_pd_max)
        else $error("power-down held too long");
    a_mr2: assert property (p_mr2)
        else $error("both self-refresh bits written");
endmodule

// >>> tb/tb.sv
/*
 Bench for the controller and device ends joined by the link.
 Assumes the APB slave in the controller and a 10 MHz clock.
*/
`timescale 1ns/100ps
module tb;
    logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] temp_band, sr_rate_q;
    logic in_pd_q, act_pd_q, dll_on_q, buf_off_q, odt_async_q, sr_ok_q, mr2_illegal_q;
    logic [4:0] tbl [5] = '{5'h01, 5'h02, 5'h0b, 5'h0c, 5'h13};
    lpe_pkg::lpe_cmd_t seq [5] = '{lpe_pkg::CMD_RD, lpe_pkg::CMD_WR, lpe_pkg::CMD_WRA,
        lpe_pkg::CMD_MRS, lpe_pkg::CMD_ZQC};
    int fails, tests_run, n_exits;
    lpe_if lpe_if_inst ();
    lpe_mem_ctrl #(.REFI_CK(1000)) lpe_mem_ctrl_inst (.sys_clk(sys_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mem(lpe_if_inst.ctrl));
    lpe_dram_end lpe_dram_end_inst (.sys_clk(sys_clk), .rst(rst), .mem(lpe_if_inst.dev),
        .temp_band(temp_band), .in_pd_q(in_pd_q), .act_pd_q(act_pd_q), .dll_on_q(dll_on_q),
        .buf_off_q(buf_off_q), .odt_async_q(odt_async_q), .sr_rate_q(sr_rate_q), .sr_ok_q(sr_ok_q),
        .mr2_illegal_q(mr2_illegal_q));
    lpe_checker #(.REFI_CK(1000)) lpe_checker_inst (.sys_clk(sys_clk), .rst(rst), .cke(lpe_if_inst.cke),
        .cmd(lpe_if_inst.cmd), .ba(lpe_if_inst.ba), .addr(lpe_if_inst.addr));
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    task chk_reg(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task chk_bit(input string name, input logic exp, input logic got);
        chk_reg(name, {31'h0, exp}, {31'h0, got});
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 3000);
        rd = prdata;
        err = pslverr;
        chk_bit("apb_answer", 1'b1, pready);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task wr_cmd(input lpe_pkg::lpe_cmd_t c, input logic [2:0] b, input logic [12:0] a);
        apb(1'b1, lpe_pkg::REG_CMD, {12'h0, a, b, c});
    endtask
    task wait_pd(input logic lvl);
        int n;
        n = 0;
        while (in_pd_q !== lvl && n < 400) begin
            @(posedge sys_clk);
            n++;
        end
        chk_bit("in_pd", lvl, in_pd_q);
    endtask
    task pd(input logic fast, input logic act, input logic dll);
        wr_cmd(lpe_pkg::CMD_MRS, lpe_pkg::MR_BA_MR0, {fast, 12'h0});
        wr_cmd(act ? lpe_pkg::CMD_ACT : lpe_pkg::CMD_PRE, 3'h1, 13'h0400);
        apb(1'b1, lpe_pkg::REG_CTRL, {30'h0, dll, 1'b1});
        wait_pd(1'b1);
        repeat (3) @(posedge sys_clk);
        chk_bit("act_pd", act, act_pd_q);
        chk_bit("dll_on", act | fast, dll_on_q);
        chk_bit("buf_off", 1'b1, buf_off_q);
        chk_bit("odt_async", !act && !fast, odt_async_q);
        apb(1'b0, lpe_pkg::REG_STAT, 32'h0);
        chk_bit("dll_owed", !dll, rd[4]);
        apb(1'b1, lpe_pkg::REG_CTRL, 32'h0);
        wait_pd(1'b0);
        repeat (16) @(posedge sys_clk);
        chk_bit("odt_async_off", 1'b0, odt_async_q);
        wr_cmd(lpe_pkg::CMD_MRS, lpe_pkg::MR_BA_MR0, {fast, 3'h0, 1'b1, 8'h0});
        wr_cmd(lpe_pkg::CMD_PRE, 3'h0, 13'h0400);
        apb(1'b0, lpe_pkg::REG_STAT, 32'h0);
        chk_bit("dll_owed_clr", 1'b0, rd[4]);
        $display("test power-down %0d%0d%0d done", fast, act, dll);
    endtask
    task give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        give_verdict();
    end
    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata, temp_band, fails, tests_run} = '0;
        rst = 1'b1;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        chk_bit("cke_reset", 1'b1, lpe_if_inst.cke);
        chk_bit("dll_reset", 1'b1, dll_on_q);
        apb(1'b0, lpe_pkg::REG_CTRL, 32'h0);
        chk_reg("ctrl_reset", 32'h0, rd);
        apb(1'b0, 8'h0c, 32'h0);
        chk_bit("unmapped", 1'b1, err);
        $display("test reset done");
        pd(1'b1, 1'b0, 1'b1);
        pd(1'b0, 1'b0, 1'b0);
        pd(1'b0, 1'b1, 1'b1);
        for (int i = 0; i < 5; i++) begin
            wr_cmd(lpe_pkg::CMD_ACT, 3'h2, 13'h0);
            wr_cmd(seq[i], 3'h2 - {2'h0, seq[i] == lpe_pkg::CMD_MRS}, 13'h0);
            apb(1'b0, lpe_pkg::REG_STAT, 32'h0);
            chk_bit("interval", 1'b0, rd[0]);
            apb(1'b1, lpe_pkg::REG_CTRL, 32'h3);
            wait_pd(1'b1);
            apb(1'b1, lpe_pkg::REG_CTRL, 32'h0);
            wait_pd(1'b0);
            wr_cmd(lpe_pkg::CMD_PRE, 3'h0, 13'h0400);
        end
        $display("test command intervals done");
        wr_cmd(lpe_pkg::CMD_MRS, lpe_pkg::MR_BA_MR0, 13'h1000);
        apb(1'b1, lpe_pkg::REG_CTRL, 32'h3);
        wait_pd(1'b1);
        // Refresh falling due forces an exit; a refresh then delays re-entry
        n_exits = 0;
        while (in_pd_q === 1'b1 && n_exits < 1500) begin
            @(posedge sys_clk);
            n_exits++;
        end
        chk_bit("forced_exit", 1'b0, in_pd_q);
        wr_cmd(lpe_pkg::CMD_REF, 3'h0, 13'h0);
        wait_pd(1'b1);
        apb(1'b0, lpe_pkg::REG_STAT, 32'h0);
        chk_bit("ref_served", 1'b0, rd[2]);
        apb(1'b1, lpe_pkg::REG_CTRL, 32'h0);
        wait_pd(1'b0);
        $display("test long power-down done");
        for (int i = 0; i < 5; i++) begin
            temp_band <= tbl[i][2:1];
            wr_cmd(lpe_pkg::CMD_MRS, lpe_pkg::MR_BA_MR2, {5'h0, tbl[i][3], tbl[i][4], 6'h0});
            repeat (3) @(posedge sys_clk);
            chk_bit("sr_ok", tbl[i][0], sr_ok_q);
            chk_reg("sr_rate", {30'h0, tbl[i][4] ? tbl[i][2:1] : {1'b0, tbl[i][3]}}, {30'h0, sr_rate_q});
        end
        wr_cmd(lpe_pkg::CMD_MRS, lpe_pkg::MR_BA_MR2, 13'h00c0);
        repeat (3) @(posedge sys_clk);
        chk_bit("mr2_illegal", 1'b0, mr2_illegal_q);
        chk_bit("sr_ok_auto", 1'b1, sr_ok_q);
        $display("test self-refresh options done");
        give_verdict();
    end
endmodule
